// >>> verilog/wtc_pkg.sv
// How it works
// - total torque sums inertia, friction, bias, pulse, diameter and auxiliary torque.
// - friction, bias, diameter, auxiliary clamp at 100%; add inertia, pulse, clamp 150%.
// - inertia direction 0 compensates acceleration, 1 deceleration; resets to 0.
// - line speed sampled each interval; sample interval setting resets to 1.
// - trend reads 0 decelerating, 1 steady, 2 accelerating.
// - inertia torque only during a ramp, from gain times speed change.
// - friction torque is friction gain times line speed.
// - breakaway fires only when line speed exceeds threshold, reset 1.00%.
// - after firing, rearm only once line speed returns to 0.00%.
// - breakaway torque equals level for duration (reset 0.1 s), then zero.
// - diameter trim, reset 100.00%, scales diameter torque.
// - diameter torque rises in proportion to diameter ratio.
// - auxiliary torque, reset 0.00%, joins the first summing stage.
// - diameter ratio input is diameter over maximum diameter.
// - tension demand input is the tapered tension value.
package wtc_pkg;
	// =========================================================
	// register indices, byte address is four times the index
	localparam logic [9:0] IDX_TRIM = 10'h124;
	localparam logic [9:0] IDX_DIAM_OUT = 10'h125;
	localparam logic [9:0] IDX_DIR = 10'h126;
	localparam logic [9:0] IDX_INTERVAL = 10'h127;
	localparam logic [9:0] IDX_IGAIN = 10'h128;
	localparam logic [9:0] IDX_TREND = 10'h129;
	localparam logic [9:0] IDX_INERTIA_OUT = 10'h12a;
	localparam logic [9:0] IDX_FGAIN = 10'h12b;
	localparam logic [9:0] IDX_FRIC_OUT = 10'h12c;
	localparam logic [9:0] IDX_BIAS = 10'h12d;
	localparam logic [9:0] IDX_THRESH = 10'h12e;
	localparam logic [9:0] IDX_LEVEL = 10'h12f;
	localparam logic [9:0] IDX_DURATION = 10'h130;
	localparam logic [9:0] IDX_PULSE_OUT = 10'h131;
	localparam logic [9:0] IDX_AUX = 10'h132;
	localparam logic [9:0] IDX_TOTAL = 10'h133;
	// =========================================================
	// reset values, percentages in hundredths, durations in tenths of a second
	localparam logic [15:0] RST_TRIM = 16'h2710;
	localparam logic RST_DIR = 1'b0;
	localparam logic [15:0] RST_INTERVAL = 16'h0001;
	localparam logic [15:0] RST_THRESH = 16'h0064;
	localparam logic [15:0] RST_DURATION = 16'h0001;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	// =========================================================
	// arithmetic scale and limits
	localparam logic signed [47:0] FULL_SCALE = 48'sh2710;
	localparam logic signed [47:0] LIM_STAGE1 = 48'sh2710;
	localparam logic signed [47:0] LIM_TOTAL = 48'sh3a98;
	localparam logic signed [47:0] INERTIA_DIV = 48'sh64;
	// =========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 32'h4;
	localparam int unsigned PULSE_UNIT_NS = 32'h05f5e100;
	localparam int unsigned SAMPLE_UNIT_NS = 32'h00989680;
	localparam int unsigned PULSE_UNIT_CYCLES = PULSE_UNIT_NS / CLK_PERIOD_NS;
	localparam int unsigned SAMPLE_UNIT_CYCLES = SAMPLE_UNIT_NS / CLK_PERIOD_NS;
	// =========================================================
	// bus
	localparam int unsigned ADDR_W = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {TREND_DECEL = 2'h0, TREND_STEADY = 2'h1, TREND_ACCEL = 2'h2} wtc_trend_type;
	typedef enum logic [1:0] {PULSE_ARMED = 2'b00, PULSE_FIRING = 2'b01, PULSE_SPENT = 2'b11} wtc_pulse_type;
endpackage

// >>> verilog/wtc_sensorless_tension_torque.sv
`timescale 1ns/100ps
`default_nettype none
module wtc_sensorless_tension_torque #(
	parameter int unsigned PULSE_UNIT_CYCLES = wtc_pkg::PULSE_UNIT_CYCLES,
	parameter int unsigned SAMPLE_UNIT_CYCLES = wtc_pkg::SAMPLE_UNIT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [15:0] line_speed,
	input wire logic [15:0] tension_demand,
	input wire logic [15:0] diameter_ratio,
	input wire logic [15:0] static_bias,
	output logic [15:0] total_torque,
	output logic breakaway_active
);
	typedef struct packed {
		logic [15:0] trim;
		logic dir;
		logic [15:0] interval;
		logic [15:0] igain;
		logic [15:0] fgain;
		logic [15:0] thresh;
		logic [15:0] level;
		logic [15:0] duration;
		logic [15:0] aux;
		logic [15:0] diam;
		logic [15:0] fric;
		logic [15:0] bias;
		logic [15:0] inertia;
		logic [15:0] total;
		logic [15:0] speed_prev;
		wtc_pkg::wtc_trend_type trend;
		wtc_pkg::wtc_pulse_type pstate;
		logic [31:0] base_cnt;
		logic [15:0] interval_cnt;
		logic [31:0] pulse_base_cnt;
		logic [15:0] pulse_tenths;
		logic aw_got;
		logic [9:0] aw_idx;
		logic w_got;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wtc_state_type;

	wtc_state_type st_reg;
	wtc_state_type st_next;

	// =========================================================
	// helpers
	function automatic logic signed [15:0] sat(input logic signed [47:0] v, input logic signed [47:0] lim);
		if (v > lim)
			return lim[15:0];
		else if (v < -lim)
			return 16'(-lim);
		else
			return v[15:0];
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[15:8] = d[15:8];
		return r;
	endfunction

	function automatic logic signed [47:0] wide(input logic [15:0] x);
		return 48'($signed(x));
	endfunction

	// =========================================================
	// arithmetic
	logic signed [47:0] tension_scaled;
	logic signed [47:0] stage1_sum;
	logic signed [47:0] delta;
	logic signed [47:0] delta_abs;
	logic signed [15:0] diam_v;
	logic signed [15:0] fric_v;
	logic signed [15:0] stage1_v;
	logic signed [15:0] pulse_v;
	logic signed [15:0] total_v;
	logic base_wrap;
	logic sample_tick;
	logic dir_match;
	logic pulse_unit_wrap;

	always_comb
	begin
		// diameter torque = trim * tension * ratio, full scale saturated
		tension_scaled = wide(st_reg.trim) * wide(tension_demand) / wtc_pkg::FULL_SCALE;
		diam_v = sat(tension_scaled * wide(diameter_ratio) / wtc_pkg::FULL_SCALE, wtc_pkg::FULL_SCALE);
		fric_v = sat(wide(st_reg.fgain) * wide(line_speed) / wtc_pkg::FULL_SCALE, wtc_pkg::FULL_SCALE);
		// first stage works on registered components so the sum is one cycle behind the inputs
		stage1_sum = wide(st_reg.fric) + wide(st_reg.bias) + wide(st_reg.diam) + wide(st_reg.aux);
		stage1_v = sat(stage1_sum, wtc_pkg::LIM_STAGE1);
		pulse_v = (st_reg.pstate == wtc_pkg::PULSE_FIRING) ? st_reg.level : wtc_pkg::RST_ZERO;
		total_v = sat(wide(stage1_v) + wide(st_reg.inertia) + wide(pulse_v), wtc_pkg::LIM_TOTAL);
		delta = wide(line_speed) - wide(st_reg.speed_prev);
		delta_abs = (delta < 0) ? -delta : delta;
		base_wrap = (st_reg.base_cnt == SAMPLE_UNIT_CYCLES - 1);
		// an interval of zero behaves as one
		sample_tick = base_wrap && (st_reg.interval_cnt + 16'h0001 >= st_reg.interval);
		pulse_unit_wrap = (st_reg.pulse_base_cnt == PULSE_UNIT_CYCLES - 1);
		dir_match = (st_reg.dir == 1'b0) ? (delta > 0) : (delta < 0);
	end

	// =========================================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		st_next.diam = diam_v;
		st_next.fric = fric_v;
		st_next.bias = static_bias;
		st_next.total = total_v;

		// sample interval counting
		st_next.base_cnt = base_wrap ? 32'h0 : st_reg.base_cnt + 32'h1;
		if (sample_tick)
			st_next.interval_cnt = 16'h0000;
		else if (base_wrap)
			st_next.interval_cnt = st_reg.interval_cnt + 16'h0001;
		if (sample_tick)
		begin
			st_next.speed_prev = line_speed;
			if (delta > 0)
				st_next.trend = wtc_pkg::TREND_ACCEL;
			else if (delta < 0)
				st_next.trend = wtc_pkg::TREND_DECEL;
			else
				st_next.trend = wtc_pkg::TREND_STEADY;
			// only a ramp in the selected direction produces inertia torque
			if (dir_match)
				st_next.inertia = sat(wide(st_reg.igain) * delta_abs / wtc_pkg::INERTIA_DIV, wtc_pkg::LIM_TOTAL);
			else
				st_next.inertia = wtc_pkg::RST_ZERO;
		end

		// breakaway pulse
		st_next.pulse_base_cnt = 32'h0;
		case (st_reg.pstate)
			wtc_pkg::PULSE_ARMED:
			begin
				st_next.pulse_tenths = 16'h0000;
				if ($signed(line_speed) > $signed(st_reg.thresh))
					st_next.pstate = (st_reg.duration == 16'h0000) ? wtc_pkg::PULSE_SPENT : wtc_pkg::PULSE_FIRING;
			end
			wtc_pkg::PULSE_FIRING:
			begin
				st_next.pulse_base_cnt = pulse_unit_wrap ? 32'h0 : st_reg.pulse_base_cnt + 32'h1;
				if (pulse_unit_wrap)
				begin
					st_next.pulse_tenths = st_reg.pulse_tenths + 16'h0001;
					if (st_reg.pulse_tenths + 16'h0001 >= st_reg.duration)
						st_next.pstate = wtc_pkg::PULSE_SPENT;
				end
			end
			wtc_pkg::PULSE_SPENT:
			begin
				if ($signed(line_speed) <= $signed(wtc_pkg::RST_ZERO))
					st_next.pstate = wtc_pkg::PULSE_ARMED;
			end
			default:
				st_next.pstate = wtc_pkg::PULSE_SPENT;
		endcase

		// write channel, address and data taken in either order
		if (awvalid && awready)
		begin
			st_next.aw_got = 1'b1;
			st_next.aw_idx = awaddr[11:2];
		end
		if (wvalid && wready)
		begin
			st_next.w_got = 1'b1;
			st_next.wd = wdata;
			st_next.ws = wstrb;
		end
		if (st_reg.bvalid && bready)
			st_next.bvalid = 1'b0;
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
		begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wtc_pkg::RESP_OKAY;
			case (st_reg.aw_idx)
				wtc_pkg::IDX_TRIM: st_next.trim = merge(st_reg.trim, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_DIR: if (st_reg.ws[0]) st_next.dir = st_reg.wd[0];
				wtc_pkg::IDX_INTERVAL: st_next.interval = merge(st_reg.interval, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_IGAIN: st_next.igain = merge(st_reg.igain, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_FGAIN: st_next.fgain = merge(st_reg.fgain, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_THRESH: st_next.thresh = merge(st_reg.thresh, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_LEVEL: st_next.level = merge(st_reg.level, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_DURATION: st_next.duration = merge(st_reg.duration, st_reg.wd, st_reg.ws);
				wtc_pkg::IDX_AUX: st_next.aux = merge(st_reg.aux, st_reg.wd, st_reg.ws);
				// read-only words accept the write and keep their value
				wtc_pkg::IDX_DIAM_OUT, wtc_pkg::IDX_TREND, wtc_pkg::IDX_INERTIA_OUT, wtc_pkg::IDX_FRIC_OUT,
				wtc_pkg::IDX_BIAS, wtc_pkg::IDX_PULSE_OUT, wtc_pkg::IDX_TOTAL: st_next.bresp = wtc_pkg::RESP_OKAY;
				default: st_next.bresp = wtc_pkg::RESP_SLVERR;
			endcase
		end

		// read channel
		if (st_reg.rvalid && rready)
			st_next.rvalid = 1'b0;
		if (arvalid && arready)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = wtc_pkg::RESP_OKAY;
			st_next.rdata = 32'h0;
			case (araddr[11:2])
				wtc_pkg::IDX_TRIM: st_next.rdata[15:0] = st_reg.trim;
				wtc_pkg::IDX_DIAM_OUT: st_next.rdata[15:0] = st_reg.diam;
				wtc_pkg::IDX_DIR: st_next.rdata[0] = st_reg.dir;
				wtc_pkg::IDX_INTERVAL: st_next.rdata[15:0] = st_reg.interval;
				wtc_pkg::IDX_IGAIN: st_next.rdata[15:0] = st_reg.igain;
				wtc_pkg::IDX_TREND: st_next.rdata[1:0] = st_reg.trend;
				wtc_pkg::IDX_INERTIA_OUT: st_next.rdata[15:0] = st_reg.inertia;
				wtc_pkg::IDX_FGAIN: st_next.rdata[15:0] = st_reg.fgain;
				wtc_pkg::IDX_FRIC_OUT: st_next.rdata[15:0] = st_reg.fric;
				wtc_pkg::IDX_BIAS: st_next.rdata[15:0] = st_reg.bias;
				wtc_pkg::IDX_THRESH: st_next.rdata[15:0] = st_reg.thresh;
				wtc_pkg::IDX_LEVEL: st_next.rdata[15:0] = st_reg.level;
				wtc_pkg::IDX_DURATION: st_next.rdata[15:0] = st_reg.duration;
				wtc_pkg::IDX_PULSE_OUT: st_next.rdata[15:0] = pulse_v;
				wtc_pkg::IDX_AUX: st_next.rdata[15:0] = st_reg.aux;
				wtc_pkg::IDX_TOTAL: st_next.rdata[15:0] = st_reg.total;
				default: st_next.rresp = wtc_pkg::RESP_SLVERR;
			endcase
		end
	end

	// =========================================================
	// registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '0;
			st_reg.trim <= wtc_pkg::RST_TRIM;
			st_reg.dir <= wtc_pkg::RST_DIR;
			st_reg.interval <= wtc_pkg::RST_INTERVAL;
			st_reg.thresh <= wtc_pkg::RST_THRESH;
			st_reg.duration <= wtc_pkg::RST_DURATION;
			st_reg.trend <= wtc_pkg::TREND_STEADY;
			st_reg.pstate <= wtc_pkg::PULSE_ARMED;
		end
		else
			st_reg <= st_next;
	end

	assign awready = !st_reg.aw_got && !st_reg.bvalid;
	assign wready = !st_reg.w_got && !st_reg.bvalid;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = !st_reg.rvalid;
	assign rvalid = st_reg.rvalid;
	assign rdata = st_reg.rdata;
	assign rresp = st_reg.rresp;
	assign total_torque = st_reg.total;
	assign breakaway_active = (st_reg.pstate == wtc_pkg::PULSE_FIRING);

	// =========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	total_limit_a: assert property ($signed(st_reg.total) <= 16'sh3a98 && $signed(st_reg.total) >= -16'sh3a98)
		else $error("total torque beyond 150 percent");
	stage_one_limit_a: assert property ($signed(stage1_v) <= 16'sh2710 && $signed(stage1_v) >= -16'sh2710)
		else $error("first stage beyond 100 percent");
	trend_code_a: assert property (st_reg.trend != 2'h3)
		else $error("illegal trend code");
	inertia_steady_a: assert property (st_reg.trend == wtc_pkg::TREND_STEADY |-> st_reg.inertia == 16'h0000)
		else $error("inertia torque while line steady");
	inertia_hold_a: assert property (!sample_tick |=> $stable(st_reg.inertia) && $stable(st_reg.trend))
		else $error("inertia changed between samples");
	pulse_fire_a: assert property (st_reg.pstate == wtc_pkg::PULSE_ARMED && $signed(line_speed) > $signed(st_reg.thresh)
		|=> st_reg.pstate != wtc_pkg::PULSE_ARMED)
		else $error("pulse did not fire above threshold");
	pulse_quiet_a: assert property (st_reg.pstate == wtc_pkg::PULSE_ARMED && $signed(line_speed) <= $signed(st_reg.thresh)
		|=> st_reg.pstate == wtc_pkg::PULSE_ARMED)
		else $error("pulse fired below threshold");
	pulse_rearm_a: assert property (st_reg.pstate == wtc_pkg::PULSE_SPENT && $signed(line_speed) > 16'sh0000
		|=> st_reg.pstate == wtc_pkg::PULSE_SPENT)
		else $error("pulse rearmed before zero speed");
	pulse_end_a: assert property (st_reg.pstate == wtc_pkg::PULSE_FIRING |=> st_reg.pstate != wtc_pkg::PULSE_ARMED)
		else $error("pulse returned to armed while firing");
	bus_hold_a: assert property (st_reg.bvalid && !bready |=> st_reg.bvalid && $stable(st_reg.bresp))
		else $error("write response dropped");
	read_hold_a: assert property (st_reg.rvalid && !rready |=> st_reg.rvalid && $stable(st_reg.rdata))
		else $error("read data dropped");
	pulse_fired_c: cover property (st_reg.pstate == wtc_pkg::PULSE_ARMED ##1 st_reg.pstate == wtc_pkg::PULSE_FIRING);
	inertia_seen_c: cover property (sample_tick && dir_match ##1 st_reg.inertia != 16'h0000);
	write_done_c: cover property (st_reg.bvalid && bready);
	read_done_c: cover property (st_reg.rvalid && rready);
endmodule // wtc_sensorless_tension_torque
`default_nettype wire

// >>> bench/wtc_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
// =========================================================
// torque regulator at the far end; LAG of 1 answers promptly, larger values slowly
module wtc_drive_model #(
	parameter int unsigned LAG = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] torque_ref,
	output logic [15:0] torque_applied
);
	logic [15:0] pipe_reg [0:7];
	always @(posedge aclk)
	begin
		pipe_reg[0] <= aresetn ? torque_ref : 16'h0000;
		for (int i = 1; i < 8; i++)
			pipe_reg[i] <= aresetn ? pipe_reg[i - 1] : 16'h0000;
	end
	assign torque_applied = pipe_reg[LAG - 1];
endmodule // wtc_drive_model
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [1:0] OK = wtc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = wtc_pkg::RESP_SLVERR;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, breakaway_active;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] line_speed, tension_demand, diameter_ratio, static_bias, total_torque, applied, ramp, tr, t, r;
	int err_total, n_checks;
	logic [33:0] rq[$];
	logic [1:0] bq[$];

	wtc_sensorless_tension_torque #(.PULSE_UNIT_CYCLES(10), .SAMPLE_UNIT_CYCLES(4)) DUT (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .line_speed(line_speed), .tension_demand(tension_demand),
		.diameter_ratio(diameter_ratio), .static_bias(static_bias), .total_torque(total_torque),
		.breakaway_active(breakaway_active));
	wtc_drive_model #(.LAG(3)) drive (.aclk(aclk), .aresetn(aresetn), .torque_ref(total_torque),
		.torque_applied(applied));

	always #2 aclk = ~aclk;

	// =========================================================
	// compare and verdict
	task automatic chk_read(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: read got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_write(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: write response %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		err_total = err_total + rq.size() + bq.size();
		$display("checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// =========================================================
	// bus master; handshakes read at the rising edge, before the design's registers move
	task automatic rd(input logic [9:0] idx, input logic [15:0] ev, input logic [1:0] er);
		@(posedge aclk);
		rq.push_back({er, 16'h0000, (er == OK) ? ev : 16'h0000});
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [15:0] v, input logic [1:0] er);
		logic ap, wp;
		@(posedge aclk);
		bq.push_back(er);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ap = 1'b1;
		wp = 1'b1;
		while (ap || wp)
		begin
			@(posedge aclk);
			if (ap && awready)
			begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wp && wready)
			begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
		end
		do
			@(posedge aclk);
		while (!bvalid);
		bready <= 1'b0;
	endtask
	// inputs; the two extra edges cover the component and total register stages
	task automatic set_in(input logic [15:0] s, input logic [15:0] td, input logic [15:0] dr, input logic [15:0] b);
		@(posedge aclk);
		line_speed <= s;
		tension_demand <= td;
		diameter_ratio <= dr;
		static_bias <= b;
		repeat (2) @(posedge aclk);
	endtask
	task automatic ramp_to(input logic [15:0] v);
		@(posedge aclk);
		ramp <= v;
		repeat (92) @(posedge aclk);
	endtask
	function automatic logic [15:0] dexp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		longint x;
		x = longint'(a) * longint'(b) / 10000 * longint'(c) / 10000;
		return (x > 10000) ? 16'h2710 : 16'(x);
	endfunction

	always @(posedge aclk)
		if (ramp != 16'h0000)
			line_speed <= line_speed + ramp;
	always @(posedge aclk)
	begin
		if (rvalid && rready && rq.size() > 0)
			chk_read({rresp, rdata}, rq.pop_front());
		if (bvalid && bready && bq.size() > 0)
			chk_write(bresp, bq.pop_front());
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		err_total++;
		$display("unexpected at %0t: run did not finish", $time);
		wrap_up();
	end

	// =========================================================
	// main sequence
	initial
	begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h0, 4'h3};
		{line_speed, tension_demand, diameter_ratio, static_bias, ramp} = 80'h0;
		void'($urandom(68));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(wtc_pkg::IDX_TRIM, wtc_pkg::RST_TRIM, OK);
		rd(wtc_pkg::IDX_DIR, 16'h0000, OK);
		rd(wtc_pkg::IDX_INTERVAL, wtc_pkg::RST_INTERVAL, OK);
		rd(wtc_pkg::IDX_THRESH, 16'h0064, OK);
		rd(wtc_pkg::IDX_DURATION, 16'h0001, OK);
		rd(wtc_pkg::IDX_AUX, 16'h0000, OK);
		rd(wtc_pkg::IDX_TREND, 16'h0001, OK);
		// unmapped places refuse, read-only ones ignore writes
		rd(10'h134, 16'h0000, ERR);
		wr(10'h000, 16'h1234, ERR);
		wr(wtc_pkg::IDX_TOTAL, 16'h1234, OK);
		rd(wtc_pkg::IDX_TOTAL, 16'h0000, OK);
		for (int i = 0; i < 5; i++)
		begin
			tr = (i == 4) ? 16'h4e20 : 16'($urandom_range(32'h2710));
			t = (i == 4) ? 16'h2710 : 16'($urandom_range(32'h2710));
			r = (i == 4) ? 16'h2710 : 16'($urandom_range(32'h2710));
			set_in(16'h0000, t, r, 16'h0000);
			wr(wtc_pkg::IDX_TRIM, tr, OK);
			rd(wtc_pkg::IDX_DIAM_OUT, dexp(tr, t, r), OK);
			rd(wtc_pkg::IDX_TOTAL, dexp(tr, t, r), OK);
		end
		wr(wtc_pkg::IDX_FGAIN, 16'h1388, OK);
		set_in(16'h1f40, 16'h2710, 16'h2710, 16'h0bb8);
		rd(wtc_pkg::IDX_FRIC_OUT, 16'h0fa0, OK);
		rd(wtc_pkg::IDX_BIAS, 16'h0bb8, OK);
		rd(wtc_pkg::IDX_TOTAL, 16'h2710, OK);
		wr(wtc_pkg::IDX_AUX, 16'hdcd8, OK);
		rd(wtc_pkg::IDX_TOTAL, 16'h1f40, OK);
		// breakaway pulse: threshold edge, level, clamp, rearm
		wr(wtc_pkg::IDX_AUX, 16'h0000, OK);
		wr(wtc_pkg::IDX_FGAIN, 16'h0000, OK);
		wr(wtc_pkg::IDX_LEVEL, 16'h1770, OK);
		wr(wtc_pkg::IDX_DURATION, 16'h0064, OK);
		set_in(16'h0000, 16'h2710, 16'h2710, 16'h0bb8);
		set_in(16'h0064, 16'h2710, 16'h2710, 16'h0bb8);
		rd(wtc_pkg::IDX_PULSE_OUT, 16'h0000, OK);
		set_in(16'h0065, 16'h2710, 16'h2710, 16'h0bb8);
		rd(wtc_pkg::IDX_PULSE_OUT, 16'h1770, OK);
		rd(wtc_pkg::IDX_TOTAL, 16'h3a98, OK);
		repeat (1010) @(posedge aclk);
		rd(wtc_pkg::IDX_PULSE_OUT, 16'h0000, OK);
		set_in(16'h1388, 16'h2710, 16'h2710, 16'h0bb8);
		rd(wtc_pkg::IDX_PULSE_OUT, 16'h0000, OK);
		set_in(16'h0000, 16'h2710, 16'h2710, 16'h0bb8);
		set_in(16'h00c8, 16'h2710, 16'h2710, 16'h0bb8);
		rd(wtc_pkg::IDX_PULSE_OUT, 16'h1770, OK);
		wr(wtc_pkg::IDX_LEVEL, 16'h0000, OK);
		repeat (1010) @(posedge aclk);
		// inertia on a steady ramp of one count per cycle
		wr(wtc_pkg::IDX_IGAIN, 16'h09c4, OK);
		set_in(16'h03e8, 16'h2710, 16'h2710, 16'h0bb8);
		for (int n = 1; n < 8; n += 3)
		begin
			wr(wtc_pkg::IDX_INTERVAL, 16'(n), OK);
			ramp_to(16'h0001);
			rd(wtc_pkg::IDX_TREND, 16'h0002, OK);
			rd(wtc_pkg::IDX_INERTIA_OUT, 16'(n * 100), OK);
		end
		wr(wtc_pkg::IDX_DIR, 16'h0001, OK);
		ramp_to(16'h0001);
		rd(wtc_pkg::IDX_INERTIA_OUT, 16'h0000, OK);
		ramp_to(16'hffff);
		rd(wtc_pkg::IDX_TREND, 16'h0000, OK);
		rd(wtc_pkg::IDX_INERTIA_OUT, 16'h02bc, OK);
		ramp_to(16'h0000);
		rd(wtc_pkg::IDX_TREND, 16'h0001, OK);
		rd(wtc_pkg::IDX_INERTIA_OUT, 16'h0000, OK);
		repeat (4) @(posedge aclk);
		// steady line: diameter clamps the first stage, so the drive settles at full scale
		chk_read({18'h00000, applied}, {18'h00000, 16'h2710});
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
